// [core/sotd_pkg.sv]
// Constants and types for the safe output telegram decoder
// How it works
// - Bytes 0-5 payload, meaning set by mode
// - Separate bit map per configured mode
// - 11 bytes, status byte 6, CRC 7-10 MSB first
// - 5/10 pairs: byte 0 bits 0-4 select field
// - Byte 4 bit 0 warning, bit 1 protective restart
// - 100 pairs: byte 0 bits 0-4 group 1
// - 100 pairs: byte 2 group 2, joined pair
// - Multi config: byte 0 bits 0-4 bank
// - Multi config: byte 2 bits 0-4 field
package sotd_pkg;
   // ****************************************
   // Telegram layout
   // ****************************************
   localparam int TLG_BYTES = 11;      // Whole telegram length
   localparam int B_SEL_LO = 0;        // Group 1 or bank byte
   localparam int B_SEL_HI = 2;        // Group 2 byte
   localparam int B_START = 4;         // Restart command byte
   localparam int B_STATUS = 6;        // Safety-layer status
   localparam int B_CRC_TOP = 7;       // CRC most significant
   localparam int B_CRC_BOT = 10;      // CRC least significant
   localparam int SEL_LSB = 0;         // Five selection bits
   localparam int SEL_MSB = 4;
   localparam int WARN_BIT = 0;        // Warning field restart
   localparam int PROT_BIT = 1;        // Protective field restart

   // ****************************************
   // Function modes
   // ****************************************
   typedef enum logic [1:0] {
      SOTD_M_PAIRS10,
      SOTD_M_PAIRS100,
      SOTD_M_MULTI,
      SOTD_M_BAD
   } sotd_mode_type;

   // ****************************************
   // Register map
   // ****************************************
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STAT = 8'h04;
   localparam logic [7:0] OFS_SEL = 8'h08;
   localparam logic [7:0] OFS_CRC = 8'h0C;
   localparam int CTRL_EN_BIT = 0;     // Decoder enable
   localparam int CTRL_MODE_LSB = 1;   // Two mode bits
   localparam logic [2:0] CTRL_RST = 3'h0;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [31:0] RD_ZERO = 32'h0000_0000;
endpackage

// [core/sotd_decode.sv]
// Per-mode payload decoding tables
`timescale 1ns/1ps
module sotd_decode (
   input wire sotd_pkg::sotd_mode_type mode,
   input wire logic [7:0] byte_lo,
   input wire logic [7:0] byte_hi,
   input wire logic [7:0] byte_start,
   output logic [4:0] grp1,
   output logic [4:0] grp2,
   output logic [4:0] bank,
   output logic warn,
   output logic prot,
   output logic mode_ok
);
   // ****************************************
   // Field extraction
   // ****************************************
   // Reserved bits never reach any output
   wire [4:0] lo_sel = byte_lo[sotd_pkg::SEL_MSB:sotd_pkg::SEL_LSB];
   wire [4:0] hi_sel = byte_hi[sotd_pkg::SEL_MSB:sotd_pkg::SEL_LSB];
   assign warn = byte_start[sotd_pkg::WARN_BIT];
   assign prot = byte_start[sotd_pkg::PROT_BIT];

   // ****************************************
   // Mode tables
   // ****************************************
   // table per mode
   always_comb begin
      grp1 = 5'h0_0;
      grp2 = 5'h0_0;
      bank = 5'h0_0;
      mode_ok = 1'b1;
      case (mode)
         sotd_pkg::SOTD_M_PAIRS10: begin
            grp1 = lo_sel;
         end
         sotd_pkg::SOTD_M_PAIRS100: begin
            grp1 = lo_sel;
            grp2 = hi_sel;
         end
         sotd_pkg::SOTD_M_MULTI: begin
            bank = lo_sel;
            grp2 = hi_sel;
         end
         // Unsupported code refuses telegrams
         default: begin
            mode_ok = 1'b0;
         end
      endcase
   end
endmodule

// [core/sotd_top.sv]
// Safe output telegram decoder with AHB-Lite registers
//
// The register addresses and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/1ps
module sotd_top #(
   parameter int CNT_BITS = 8
) (
   input wire logic clk,
   input wire logic rst_b,
   // Telegram byte stream, same clock
   input wire logic rx_valid,
   input wire logic rx_first,
   input wire logic [7:0] rx_byte,
   input wire logic [31:0] crc_expect,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Decoded selections
   output logic [4:0] field_grp1,
   output logic [4:0] field_grp2,
   output logic [9:0] pair_sel,
   output logic [4:0] bank_sel,
   output logic restart_warn,
   output logic restart_prot,
   output logic [7:0] status_byte,
   output logic tlg_ok,
   output logic tlg_err
);
   // ****************************************
   // Elaboration checks
   // ****************************************
   if (CNT_BITS < 1 || CNT_BITS > 8) begin : g_chk
      $error("CNT_BITS must be 1 to 8");
   end

   // ****************************************
   // Storage and state
   // ****************************************
   logic [7:0] tlg_r [0:sotd_pkg::TLG_BYTES-1]; // Received bytes
   logic [3:0] idx_r;                  // Next byte index, 0 idle
   logic [2:0] ctrl_r;                 // Mode and enable
   logic ok_r;                         // Accept pulse
   logic err_r;                        // Reject pulse
   logic seen_r;                       // Any telegram accepted
   logic [CNT_BITS-1:0] good_r;        // Accepted count
   logic [CNT_BITS-1:0] bad_r;         // Rejected count
   logic [31:0] crc_r;                 // Last accepted CRC
   logic [4:0] grp1_r, grp2_r, bank_r;
   logic [9:0] pair_r;
   logic warn_r, prot_r;
   logic [7:0] stat_r;
   logic wr_pend_r;                    // Write data phase due
   logic [7:0] addr_r;                 // Captured address

   // ****************************************
   // Telegram assembly
   // ****************************************
   localparam logic [3:0] LAST_IDX = 4'(sotd_pkg::B_CRC_BOT);
   wire en = ctrl_r[sotd_pkg::CTRL_EN_BIT];
   wire sotd_pkg::sotd_mode_type mode = sotd_pkg::sotd_mode_type'(ctrl_r[2:1]);
   wire take_first = rx_valid && rx_first;
   wire take_next = rx_valid && !rx_first && idx_r != 4'h0;
   wire complete = take_next && idx_r == LAST_IDX;
   // A new start mid-frame drops the old frame
   wire broken = take_first && idx_r != 4'h0;
   wire [31:0] crc_rx = {tlg_r[sotd_pkg::B_CRC_TOP], tlg_r[sotd_pkg::B_CRC_TOP+1],
                         tlg_r[sotd_pkg::B_CRC_TOP+2], rx_byte};
   wire [4:0] d_grp1, d_grp2, d_bank;
   wire d_warn, d_prot, d_mode_ok;
   sotd_decode u_dec (
      .mode(mode),
      .byte_lo(tlg_r[sotd_pkg::B_SEL_LO]),
      .byte_hi(tlg_r[sotd_pkg::B_SEL_HI]),
      .byte_start(tlg_r[sotd_pkg::B_START]),
      .grp1(d_grp1),
      .grp2(d_grp2),
      .bank(d_bank),
      .warn(d_warn),
      .prot(d_prot),
      .mode_ok(d_mode_ok)
   );
   // Disabled decoder or wrong trailer keeps old outputs
   wire accept = complete && en && d_mode_ok && crc_rx == crc_expect;
   wire reject = (complete && !accept) || broken;

   // Index counter; byte 0 only on a start marker
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         idx_r <= 4'h0;
      end else if (take_first) begin
         idx_r <= 4'h1;
      end else if (complete) begin
         idx_r <= 4'h0;
      end else if (take_next) begin
         idx_r <= idx_r + 4'h1;
      end
   end

   // Byte store addressed by index
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < sotd_pkg::TLG_BYTES; i++) begin
            tlg_r[i] <= 8'h00;
         end
      end else if (take_first) begin
         tlg_r[0] <= rx_byte;
      end else if (take_next) begin
         tlg_r[idx_r] <= rx_byte;
      end
   end

   // ****************************************
   // Decoded outputs
   // ****************************************
   // Outputs change only on an accepted telegram
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         grp1_r <= 5'h0_0;
         grp2_r <= 5'h0_0;
         bank_r <= 5'h0_0;
         pair_r <= 10'h000;
         warn_r <= 1'b0;
         prot_r <= 1'b0;
         stat_r <= 8'h00;
         crc_r <= 32'h0000_0000;
      end else if (accept) begin
         grp1_r <= d_grp1;
         grp2_r <= d_grp2;
         bank_r <= d_bank;
         pair_r <= (mode == sotd_pkg::SOTD_M_PAIRS100) ? {d_grp2, d_grp1} : 10'h000;
         warn_r <= d_warn;
         prot_r <= d_prot;
         stat_r <= tlg_r[sotd_pkg::B_STATUS];
         crc_r <= crc_rx;
      end
   end

   // Event pulses and counters
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ok_r <= 1'b0;
         err_r <= 1'b0;
         seen_r <= 1'b0;
         good_r <= '0;
         bad_r <= '0;
      end else begin
         ok_r <= accept;
         err_r <= reject;
         seen_r <= seen_r || accept;
         good_r <= good_r + CNT_BITS'(accept);
         bad_r <= bad_r + CNT_BITS'(reject);
      end
   end

   assign field_grp1 = grp1_r;
   assign field_grp2 = grp2_r;
   assign pair_sel = pair_r;
   assign bank_sel = bank_r;
   assign restart_warn = warn_r;
   assign restart_prot = prot_r;
   assign status_byte = stat_r;
   assign tlg_ok = ok_r;
   assign tlg_err = err_r;

   // ****************************************
   // AHB-Lite slave
   // ****************************************
   // Zero wait states, always OKAY
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   wire addr_phase = hsel && hready && htrans == sotd_pkg::HTRANS_NONSEQ;

   // Address phase capture
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         addr_r <= 8'h00;
         wr_pend_r <= 1'b0;
      end else if (hready) begin
         addr_r <= addr_phase ? haddr : addr_r;
         wr_pend_r <= addr_phase && hwrite && hsize == 3'h2;
      end
   end

   // Control write in data phase; mode chosen here
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_r <= sotd_pkg::CTRL_RST;
      end else if (wr_pend_r && addr_r == sotd_pkg::OFS_CTRL) begin
         ctrl_r <= hwdata[2:0];
      end
   end

   // Read mux over flip-flops; unmapped reads zero
   wire [31:0] rd_stat = {stat_r, 6'h00, err_r, seen_r,
                          8'(bad_r), 8'(good_r)};
   // Packs to exactly one word: 4 + 1 + 1 + 5 + 10 + 1 + 5 + 5 bits
   wire [31:0] rd_sel = {4'h0, prot_r, warn_r, bank_r, pair_r, 1'b0, grp2_r, grp1_r};
   assign hrdata = (addr_r == sotd_pkg::OFS_CTRL) ? {29'h0000_0000, ctrl_r} :
                   (addr_r == sotd_pkg::OFS_STAT) ? rd_stat :
                   (addr_r == sotd_pkg::OFS_SEL) ? rd_sel :
                   (addr_r == sotd_pkg::OFS_CRC) ? crc_r : sotd_pkg::RD_ZERO;

   // ****************************************
   // Assertions
   // ****************************************
   property p_crc_msb_first;
      @(posedge clk) disable iff (!rst_b)
      ok_r |-> crc_r == $past(crc_expect) && crc_r[31:24] == tlg_r[sotd_pkg::B_CRC_TOP];
   endproperty
   a_crc_msb_first: assert property (p_crc_msb_first) else $error("CRC byte order wrong");

   property p_len;
      @(posedge clk) disable iff (!rst_b)
      ok_r |-> $past(idx_r) == LAST_IDX && idx_r == 4'h0 || $past(rx_first);
   endproperty
   a_len: assert property (p_len) else $error("Telegram length not eleven");

   property p_pairs10;
      @(posedge clk) disable iff (!rst_b)
      ok_r && $past(mode) == sotd_pkg::SOTD_M_PAIRS10 |->
         grp1_r == $past(tlg_r[0][4:0]) && grp2_r == 5'h0_0 && bank_r == 5'h0_0;
   endproperty
   a_pairs10: assert property (p_pairs10) else $error("5/10 pair decode wrong");

   property p_restart;
      @(posedge clk) disable iff (!rst_b)
      ok_r |-> warn_r == $past(tlg_r[4][0]) && prot_r == $past(tlg_r[4][1]);
   endproperty
   a_restart: assert property (p_restart) else $error("Restart bits wrong");

   property p_grp1_100;
      @(posedge clk) disable iff (!rst_b)
      ok_r && $past(mode) == sotd_pkg::SOTD_M_PAIRS100 |-> grp1_r == $past(tlg_r[0][4:0]);
   endproperty
   a_grp1_100: assert property (p_grp1_100) else $error("Group 1 wrong");

   property p_pair_100;
      @(posedge clk) disable iff (!rst_b)
      ok_r && $past(mode) == sotd_pkg::SOTD_M_PAIRS100 |->
         pair_r == {$past(tlg_r[2][4:0]), $past(tlg_r[0][4:0])};
   endproperty
   a_pair_100: assert property (p_pair_100) else $error("Field pair wrong");

   property p_multi_bank;
      @(posedge clk) disable iff (!rst_b)
      ok_r && $past(mode) == sotd_pkg::SOTD_M_MULTI |-> bank_r == $past(tlg_r[0][4:0]) && grp1_r == 5'h0_0;
   endproperty
   a_multi_bank: assert property (p_multi_bank) else $error("Bank select wrong");

   property p_multi_field;
      @(posedge clk) disable iff (!rst_b)
      ok_r && $past(mode) == sotd_pkg::SOTD_M_MULTI |-> grp2_r == $past(tlg_r[2][4:0]);
   endproperty
   a_multi_field: assert property (p_multi_field) else $error("Multi field wrong");

   property p_bad_mode;
      @(posedge clk) disable iff (!rst_b)
      complete && mode == sotd_pkg::SOTD_M_BAD |=> !ok_r && err_r ##1 $stable(grp1_r);
   endproperty
   a_bad_mode: assert property (p_bad_mode) else $error("Bad mode accepted");

   property p_hold;
      @(posedge clk) disable iff (!rst_b)
      !ok_r |-> $stable(grp1_r) && $stable(grp2_r) && $stable(bank_r) && $stable(warn_r);
   endproperty
   a_hold: assert property (p_hold) else $error("Outputs moved without telegram");
endmodule

// [tb/sotd_fhost.sv]
// Safety controller model that streams safe output telegrams
`timescale 1ns/1ps
module sotd_fhost (
   input wire logic clk,
   output logic rx_valid,
   output logic rx_first,
   output logic [7:0] rx_byte,
   output logic [31:0] crc_expect
);
   // ****************************************
   // Idle levels before the first frame
   // ****************************************
   initial begin
      rx_valid = 1'b0;
      rx_first = 1'b0;
      rx_byte = 8'h00;
      crc_expect = 32'h0000_0000;
   end

   // ****************************************
   // Frame sender
   // ****************************************
   // Short n aborts the frame; a wrong flag spoils the checksum
   // payload, status, CRC top first
   task automatic send(input logic [47:0] pay, input logic [7:0] st, input logic [31:0] crc,
                       input bit bad, input int n);
      logic [87:0] tel; // Bytes 0..10, byte 0 at top
      tel = {pay, st, crc};
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         rx_valid <= 1'b1;
         rx_first <= (i == 0);
         rx_byte <= tel[87 - 8 * i -: 8];
         crc_expect <= bad ? ~crc : crc;
      end
      @(posedge clk);
      rx_valid <= 1'b0;
      rx_first <= 1'b0;
      // Stale data inverted so nothing passes by luck
      rx_byte <= ~tel[87 - 8 * (n - 1) -: 8];
      crc_expect <= ~crc;
   endtask
endmodule

// [tb/testbench.sv]
// Self-checking bench for the safe output telegram decoder
`timescale 1ns/1ps
module testbench;
   // ****************************************
   // Signals and counters
   // ****************************************
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic hsel = 1'b0;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h0;
   logic [31:0] hwdata = 32'h0000_0000;
   logic hready; // One slave: its own ready
   logic hresp;
   logic [31:0] hrdata;
   logic rx_valid;
   logic rx_first;
   logic [7:0] rx_byte;
   logic [31:0] crc_expect;
   logic [4:0] field_grp1;
   logic [4:0] field_grp2;
   logic [4:0] bank_sel;
   logic [9:0] pair_sel;
   logic restart_warn;
   logic restart_prot;
   logic tlg_ok;
   logic tlg_err;
   logic [7:0] status_byte;
   logic [31:0] rd;
   int fails = 0;
   int compares = 0;
   int oks = 0; // Accept pulses seen
   int errs = 0; // Reject pulses seen

   always #50 clk = ~clk;

   sotd_fhost u_host (.clk(clk), .rx_valid(rx_valid), .rx_first(rx_first), .rx_byte(rx_byte),
                      .crc_expect(crc_expect));

   sotd_top u_dut (.clk(clk), .rst_b(rst_b), .rx_valid(rx_valid), .rx_first(rx_first),
                   .rx_byte(rx_byte), .crc_expect(crc_expect), .hsel(hsel), .haddr(haddr),
                   .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
                   .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
                   .field_grp1(field_grp1), .field_grp2(field_grp2), .pair_sel(pair_sel),
                   .bank_sel(bank_sel), .restart_warn(restart_warn), .restart_prot(restart_prot),
                   .status_byte(status_byte), .tlg_ok(tlg_ok), .tlg_err(tlg_err));

   // Pulse counters, one count per high cycle
   always @(posedge clk) begin
      if (tlg_ok === 1'b1) oks++;
      if (tlg_err === 1'b1) errs++;
   end

   // ****************************************
   // Tasks
   // ****************************************
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("ERROR at %0t ns: got %h, expected %h", $time, got, exp);
      end
   endtask

   // Bounded wait for an edge with ready high
   task automatic wait_ready(inout int n);
      @(posedge clk);
      while (hready !== 1'b1 && n < 50) begin
         n++;
         @(posedge clk);
      end
   endtask

   // One single word transfer, address then data phase
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rdv);
      int n;
      n = 0;
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= sotd_pkg::HTRANS_NONSEQ;
      hwrite <= wr;
      hsize <= 3'h2;
      wait_ready(n);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_ready(n);
      rdv = hrdata;
      check(hresp, 32'h0000_0000);
      if (n >= 50) fails++;
   endtask

   // Full telegram, verdict pulse one cycle after byte 10
   task automatic tlg(input logic [47:0] pay, input logic [7:0] st, input bit bad, input logic ok);
      u_host.send(pay, st, {pay[47:32], st, 8'hC3}, bad, 11);
      #1;
      check({tlg_ok, tlg_err}, {ok, ~ok});
      @(posedge clk);
      #1;
      check({tlg_ok, tlg_err}, 2'b00);
   endtask

   // Decoded outputs for the given mode
   task automatic outs(input int m, input logic [4:0] g1, input logic [4:0] g2, input logic [4:0] bk,
                       input logic [9:0] pr, input logic [1:0] rs, input logic [7:0] st);
      if (m != 2) check(field_grp1, g1);
      if (m != 0) check(field_grp2, g2);
      check({pair_sel, bank_sel}, {pr, bk});
      check({restart_prot, restart_warn}, rs);
      check(status_byte, st);
   endtask

   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // ****************************************
   // Test sequence
   // ****************************************
   initial begin
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      #1;
      check({field_grp1, field_grp2, pair_sel, bank_sel}, 25'h000_0000);
      check({restart_warn, restart_prot, tlg_ok, tlg_err, status_byte}, 12'h000);
      ahb(1'b0, sotd_pkg::OFS_CTRL, 32'h0000_0000, rd);
      check(rd, 32'h0000_0000);
      ahb(1'b0, 8'h10, 32'h0000_0000, rd);
      check(rd, 32'h0000_0000);
      // 5/10 pairs with every reserved bit set
      ahb(1'b1, sotd_pkg::OFS_CTRL, 32'h0000_0001, rd);
      tlg(48'hF5FF_FFFF_FDFF, 8'h5A, 1'b0, 1'b1);
      outs(0, 5'h15, 5'h00, 5'h00, 10'h000, 2'b01, 8'h5A);
      // 100 pairs, both groups joined
      ahb(1'b1, sotd_pkg::OFS_CTRL, 32'h0000_0003, rd);
      tlg(48'h0A00_1300_0200, 8'hA5, 1'b0, 1'b1);
      outs(1, 5'h0A, 5'h13, 5'h00, {5'h13, 5'h0A}, 2'b10, 8'hA5);
      // Multi configuration, reserved bits set
      ahb(1'b1, sotd_pkg::OFS_CTRL, 32'h0000_0005, rd);
      tlg(48'hFFFF_E4FF_03FF, 8'h3C, 1'b0, 1'b1);
      outs(2, 5'h00, 5'h04, 5'h1F, 10'h000, 2'b11, 8'h3C);
      // Bad checksum, bad mode, disabled: all refused
      tlg(48'h0101_0101_0000, 8'h11, 1'b1, 1'b0);
      ahb(1'b1, sotd_pkg::OFS_CTRL, 32'h0000_0007, rd);
      tlg(48'h0101_0101_0000, 8'h22, 1'b0, 1'b0);
      ahb(1'b1, sotd_pkg::OFS_CTRL, 32'h0000_0002, rd);
      tlg(48'h0101_0101_0000, 8'h33, 1'b0, 1'b0);
      outs(2, 5'h00, 5'h04, 5'h1F, 10'h000, 2'b11, 8'h3C);
      // Frame cut short after five bytes, then a clean one
      ahb(1'b1, sotd_pkg::OFS_CTRL, 32'h0000_0003, rd);
      u_host.send(48'h1F00_1F00_0300, 8'h44, 32'h0000_0000, 1'b0, 5);
      tlg(48'h0100_0200_0000, 8'h55, 1'b0, 1'b1);
      outs(1, 5'h01, 5'h02, 5'h00, {5'h02, 5'h01}, 2'b00, 8'h55);
      check(oks, 32'h0000_0004);
      check(errs, 32'h0000_0004);
      // Read-only status ignores writes; seen flag set, no pulse left
      ahb(1'b1, sotd_pkg::OFS_STAT, 32'hFFFF_FFFF, rd);
      ahb(1'b0, sotd_pkg::OFS_STAT, 32'h0000_0000, rd);
      check(rd, 32'h5501_0404);
      // Selection word of the last telegram, packed per register map
      ahb(1'b0, sotd_pkg::OFS_SEL, 32'h0000_0000, rd);
      check(rd, 32'h0002_0841);
      // Trailer of the last telegram, top byte first
      ahb(1'b0, sotd_pkg::OFS_CRC, 32'h0000_0000, rd);
      check(rd, 32'h0100_55C3);
      ahb(1'b0, sotd_pkg::OFS_CTRL, 32'h0000_0000, rd);
      check(rd, 32'h0000_0003);
      tally_and_finish();
   end

   // Watchdog, far beyond the roughly 145 cycles needed
   initial begin
      #200000;
      fails++;
      tally_and_finish();
   end
endmodule
